/* hw/bbc_top.sv */
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module bbc_top (
  input  wire logic        mclk_in,      // 100 MHz clock
  input  wire logic        nrst_in,      // Async reset, low
  input  wire logic [3:0]  addr_in,      // Register index
  input  wire logic [15:0] wdata_in,     // Write data
  input  wire logic        wr_in,        // Write strobe
  input  wire logic        rd_in,        // Read strobe
  output logic      [15:0] rdata_out,    // Read data
  input  wire logic        cyc_in,       // Bus cycle valid
  input  wire logic [31:0] bus_addr_in,  // Bus address
  input  wire logic        periph_in,    // Peripheral master
  input  wire logic        fetch_in,     // Instruction fetch
  input  wire logic        overrun_in,   // Overrun fetch
  input  wire logic        dest_in,      // Non-delay dest fetch
  input  wire logic        pair_in,      // Second of paired fetch
  input  wire logic        write_in,     // Write cycle
  input  wire logic [1:0]  size_in,      // Operand size
  input  wire logic        preempt_in,   // Higher exception taken
  input  wire logic [3:0]  imask_in,     // Processor mask level
  input  wire logic        ack_in,       // Break accepted
  output logic             break_req_out, // Break request
  output logic      [3:0]  break_lvl_out, // Request level
  output logic      [31:0] break_pc_out,  // Saved address
  output logic             addr_err_out,  // Address error first
  output logic             irq_out        // Status interrupt
);
  import bbc_pkg::*;
  // ==========================================================
  // State
  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
    logic [15:0] sel;
    logic [15:0] sel_pair;
    logic [2:0]  status;
    logic [2:0]  mask;
    logic [15:0] rdata;
    logic        pend;
    logic [31:0] pc;
    logic        aerr;
    bbc_seq_e    seq;
    logic        irq;
  } bbc_state_s;
  bbc_state_s q, d;
  logic        rst_a;
  logic        rst_b;
  logic        rst_n;
  logic [31:0] cmp_addr;
  logic [15:0] use_sel;
  logic        hit_raw;
  logic        is_data_view;
  logic [2:0]  ev;
  assign rst_n    = rst_b;
  assign cmp_addr = {q.high, q.low};
  // Second half of a paired fetch keeps the condition of the first
  assign use_sel  = pair_in ? q.sel_pair : q.sel;
  // Overrun fetch seen as data read when data enabled
  assign is_data_view = fetch_in && overrun_in;
  // ==========================================================
  // Matcher
  bbc_match u_match (
    .select_in   (use_sel),
    .addr_in     (cmp_addr),
    .bus_addr_in (bus_addr_in),
    .periph_in   (periph_in),
    .fetch_in    (fetch_in && !is_data_view),
    .write_in    (write_in),
    .size_in     (fetch_in ? SIZE_WORD : size_in),
    .hit_out     (hit_raw)
  );
  // ==========================================================
  // Alignment of a data cycle against its operand size
  function automatic logic is_aligned(input logic [1:0] sz, input logic [1:0] lo);
    return !((sz == SIZE_WORD && lo[0]) || (sz == SIZE_LONG && lo != 2'h0));
  endfunction : is_aligned
  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    ev = 3'h0;
    // Condition captured at the first fetch of a possible pair
    if (cyc_in && fetch_in && !pair_in) begin
      d.sel_pair = q.sel;
    end
    // Register writes
    if (wr_in) begin
      unique case (addr_in)
        ADDR_BREAK_HIGH:   d.high = wdata_in;
        ADDR_BREAK_LOW:    d.low = wdata_in;
        ADDR_CYCLE_SELECT: d.sel = {8'h00, wdata_in[7:0]};
        ADDR_STATUS:       d.status = q.status & ~wdata_in[2:0];
        ADDR_MASK:         d.mask = wdata_in[2:0];
        default:           d.rdata = q.rdata;
      endcase
    end
    // Reads, answered next cycle
    d.rdata = 16'h0000;
    if (rd_in) begin
      unique case (addr_in)
        ADDR_BREAK_HIGH:   d.rdata = q.high;
        ADDR_BREAK_LOW:    d.rdata = q.low;
        ADDR_CYCLE_SELECT: d.rdata = q.sel;
        ADDR_STATUS:       d.rdata = {13'h0000, q.status};
        ADDR_MASK:         d.rdata = {13'h0000, q.mask};
        ADDR_MON:          d.rdata = {12'h000, q.pend, q.aerr, q.seq};
        default:           d.rdata = 16'h0000;
      endcase
    end
    // Cycle evaluation
    if (cyc_in && !q.pend && q.seq == BBC_IDLE) begin
      if (fetch_in && !overrun_in && dest_in) begin
        ev = 3'h0;
      end else if (fetch_in && !overrun_in && bus_addr_in[0]) begin
        // Only a branch can fetch an odd target
        if (bus_addr_in == cmp_addr && use_sel[FD_POS] && use_sel[MASTER_POS]
            && use_sel[DIR_POS] && !periph_in) begin
          d.seq = BBC_AERR;
          d.aerr = 1'b1;
          d.pc = bus_addr_in;
          ev[STAT_ADDRERR] = 1'b1;
        end
      end else if (fetch_in && !overrun_in && hit_raw) begin
        d.pend = 1'b1;
        d.pc = bus_addr_in;
        ev[STAT_FETCH] = 1'b1;
      end else if ((!fetch_in || overrun_in) && hit_raw) begin
        // Word and long cycles sit aligned; odd compare never hits
        if (is_aligned(size_in, bus_addr_in[1:0])) begin
          d.pend = 1'b1;
          d.pc = bus_addr_in;
          ev[STAT_DATA] = 1'b1;
        end
      end
    end
    // Address error first, then the break
    if (q.seq == BBC_AERR && ack_in) begin
      d.aerr = 1'b0;
      d.seq = BBC_BREAK;
      d.pend = 1'b1;
    end else if (q.seq == BBC_BREAK && ack_in && q.pend) begin
      d.seq = BBC_IDLE;
    end
    // Pending request held while masked at its level
    if (q.pend && ack_in && imask_in < BREAK_LEVEL && q.seq != BBC_AERR) begin
      d.pend = 1'b0;
      d.seq = BBC_IDLE;
    end
    if (q.pend && preempt_in) begin
      d.pend = 1'b0;
    end
    // Set wins over clear
    d.status = d.status | ev;
    d.irq = |(d.status & d.mask);
  end
  // ==========================================================
  // Registers
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_a <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_a <= 1'b1;
      rst_b <= rst_a;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      q.high     <= 16'h0000;
      q.low      <= 16'h0000;
      q.sel      <= SELECT_RESET;
      q.sel_pair <= SELECT_RESET;
      q.status   <= 3'h0;
      q.mask     <= 3'h0;
      q.rdata    <= 16'h0000;
      q.pend     <= 1'b0;
      q.pc       <= 32'h0000_0000;
      q.aerr     <= 1'b0;
      q.seq      <= BBC_IDLE;
      q.irq      <= 1'b0;
    end else begin
      q.high     <= d.high;
      q.low      <= d.low;
      q.sel      <= d.sel;
      q.sel_pair <= d.sel_pair;
      q.status   <= d.status;
      q.mask     <= d.mask;
      q.rdata    <= d.rdata;
      q.pend     <= d.pend;
      q.pc       <= d.pc;
      q.aerr     <= d.aerr;
      q.seq      <= d.seq;
      q.irq      <= d.irq;
    end
  end
  // ==========================================================
  // Outputs
  assign rdata_out     = q.rdata;
  assign break_req_out = q.pend;
  assign break_lvl_out = BREAK_LEVEL;
  assign break_pc_out  = q.pc;
  assign addr_err_out  = q.aerr;
  assign irq_out       = q.irq;
  // ==========================================================
  // Checks
  sequence fetch_hit_s;
    cyc_in && fetch_in && !overrun_in && !dest_in && !bus_addr_in[0] && hit_raw
      && !q.pend && q.seq == BBC_IDLE;
  endsequence
  fetch_break_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    fetch_hit_s |=> break_req_out && break_pc_out == $past(bus_addr_in))
    else $error("fetch hit without break");
  write_fetch_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cyc_in && fetch_in && !overrun_in && use_sel[DIR_POS+:2] == 2'h2 |-> !hit_raw)
    else $error("write fetch matched");
  periph_fetch_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cyc_in && fetch_in && !overrun_in && use_sel[MASTER_POS+:2] == 2'h2 |-> !hit_raw)
    else $error("peripheral fetch matched");
  zero_field_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    (use_sel[MASTER_POS+:2] == 2'h0 || use_sel[FD_POS+:2] == 2'h0
      || use_sel[DIR_POS+:2] == 2'h0) |-> !hit_raw)
    else $error("zero field matched");
  dest_skip_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cyc_in && fetch_in && !overrun_in && dest_in && !q.pend && q.seq == BBC_IDLE
      |=> !break_req_out)
    else $error("destination fetch broke");
  aerr_order_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    q.seq == BBC_AERR |-> !break_req_out)
    else $error("break before address error");
  held_mask_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    break_req_out && imask_in == BREAK_LEVEL && !preempt_in |=> break_req_out)
    else $error("masked break dropped");
  irq_level_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    irq_out == |(q.status & q.mask))
    else $error("interrupt level wrong");
  // ==========================================================
  // Data, pairing and acceptance checks
  sequence data_hit_s;
    cyc_in && (!fetch_in || overrun_in) && hit_raw && is_aligned(size_in, bus_addr_in[1:0])
      && !q.pend && q.seq == BBC_IDLE;
  endsequence
  sequence idle_cycle_s;
    cyc_in && !q.pend && q.seq == BBC_IDLE;
  endsequence
  sequence aerr_ack_s;
    q.seq == BBC_AERR && ack_in;
  endsequence
  data_break_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    data_hit_s |=> break_req_out && break_pc_out == $past(bus_addr_in))
    else $error("data hit without break");
  odd_word_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    idle_cycle_s ##0 (!fetch_in && size_in == SIZE_WORD && bus_addr_in[0]) |=> !break_req_out)
    else $error("odd word access broke");
  odd_fetch_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    idle_cycle_s ##0 (fetch_in && !overrun_in && bus_addr_in[0]) |=> !break_req_out)
    else $error("odd fetch broke directly");
  overrun_skip_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    idle_cycle_s ##0 (fetch_in && overrun_in && !use_sel[FD_POS+1]) |=> !break_req_out)
    else $error("overrun fetch broke");
  aerr_step_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    aerr_ack_s |=> break_req_out && !addr_err_out)
    else $error("break missing after address error");
  pair_latch_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    cyc_in && fetch_in && !pair_in |=> q.sel_pair == $past(q.sel))
    else $error("paired condition not latched");
  preempt_drop_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    break_req_out && preempt_in |=> !break_req_out)
    else $error("preempted break kept");
  accept_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    break_req_out && ack_in && imask_in < BREAK_LEVEL && q.seq != BBC_AERR |=> !break_req_out)
    else $error("accepted break kept");
  read_idle_a: assert property (@(posedge mclk_in) disable iff (!rst_n)
    !rd_in |=> rdata_out == 16'h0000)
    else $error("read data outside slot");
endmodule : bbc_top
`default_nettype wire

/* hw/bbc_pkg.sv */
package bbc_pkg;
  // ==========================================================
  // Register map
  localparam logic [3:0] ADDR_BREAK_HIGH   = 4'h0;
  localparam logic [3:0] ADDR_BREAK_LOW    = 4'h1;
  localparam logic [3:0] ADDR_CYCLE_SELECT = 4'h2;
  localparam logic [3:0] ADDR_STATUS       = 4'h3;
  localparam logic [3:0] ADDR_MASK         = 4'h4;
  localparam logic [3:0] ADDR_MON          = 4'h5;
  // ==========================================================
  // Cycle select field positions
  localparam int MASTER_POS = 6;
  localparam int FD_POS     = 4;
  localparam int DIR_POS    = 2;
  localparam int SIZE_POS   = 0;
  // ==========================================================
  // Reset values and codes
  localparam logic [15:0] SELECT_RESET = 16'h0000;
  localparam logic [1:0]  SIZE_BYTE    = 2'h1;
  localparam logic [1:0]  SIZE_WORD    = 2'h2;
  localparam logic [1:0]  SIZE_LONG    = 2'h3;
  localparam logic [3:0]  BREAK_LEVEL  = 4'hf;
  localparam int          STAT_FETCH   = 0;
  localparam int          STAT_DATA    = 1;
  localparam int          STAT_ADDRERR = 2;
  // Address error then break, two-step sequence
  typedef enum logic [1:0] {
    BBC_IDLE  = 2'b00,
    BBC_AERR  = 2'b01,
    BBC_BREAK = 2'b10
  } bbc_seq_e;
endpackage : bbc_pkg

/* hw/bbc_match.sv */
`timescale 1ns/1ps
`default_nettype none
module bbc_match (
  input  wire logic [15:0] select_in,  // Cycle select
  input  wire logic [31:0] addr_in,    // Compare address
  input  wire logic [31:0] bus_addr_in, // Bus address
  input  wire logic        periph_in,  // Peripheral master
  input  wire logic        fetch_in,   // Instruction fetch
  input  wire logic        write_in,   // Write cycle
  input  wire logic [1:0]  size_in,    // Operand size
  output logic             hit_out     // Conditions met
);
  import bbc_pkg::*;
  logic [1:0] m, f, d, s;
  logic       ok_m, ok_f, ok_d, ok_s;
  // ==========================================================
  // Field decode
  always_comb begin
    m = select_in[MASTER_POS+:2];
    f = select_in[FD_POS+:2];
    d = select_in[DIR_POS+:2];
    s = select_in[SIZE_POS+:2];
    // Peripheral masters never fetch, so a fetch there never matches
    ok_m = periph_in ? (m[1] && !fetch_in) : m[0];
    ok_f = fetch_in ? f[0] : f[1];
    ok_d = (write_in && !fetch_in) ? d[1] : d[0];
    ok_s = (s == 2'h0) || (s == size_in);
    hit_out = ok_m && ok_f && ok_d && ok_s && (bus_addr_in == addr_in);
  end
endmodule : bbc_match
`default_nettype wire

/* bench/bbc_interrupt_controller_unit_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bbc_interrupt_controller_unit_model (
  input  wire logic       mclk_in,  // Clock
  input  wire logic       nrst_in,  // Reset, low
  input  wire logic       req_in,   // Break or address error pending
  input  wire logic [3:0] imask_in, // Processor mask level
  output logic            ack_out   // Acceptance pulse
);
  // ============================================================
  // Acceptance
  // Level 15 request taken only below mask 15; one pulse, then a gap
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ack_out <= 1'b0;
    end else begin
      ack_out <= req_in && (imask_in < 4'hf) && !ack_out;
    end
  end
endmodule : bbc_interrupt_controller_unit_model
`default_nettype wire

/* bench/tb_bbc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_bbc_top;
  import bbc_pkg::*;
  // Cycle flags: periph, fetch, overrun, dest, pair, write, size
  localparam logic [7:0] FT = 8'h42, OV = 8'h62, DS = 8'h52, PR = 8'h4a;
  localparam logic [7:0] WW = 8'h06, RW = 8'h02, PL = 8'h83, PF = 8'hc2;
  logic        mclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, cyc = 1'b0;
  logic        preempt = 1'b0, ack, req, aerr, irq;
  logic [3:0]  addr = 4'h0, imask = 4'hf, lvl;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [31:0] bus_addr = 32'h0, pc;
  logic [7:0]  fl = 8'h00;
  logic [15:0] sels [3] = '{16'h0014, 16'h0044, 16'h0050};
  int          num_errors = 0, check_count = 0, cycles = 0;

  // ============================================================
  // Clock, hang guard, design and interrupt controller
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  bbc_top bbc_top_inst (.mclk_in(mclk), .nrst_in(nrst), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .cyc_in(cyc), .bus_addr_in(bus_addr),
    .periph_in(fl[7]), .fetch_in(fl[6]), .overrun_in(fl[5]), .dest_in(fl[4]),
    .pair_in(fl[3]), .write_in(fl[2]), .size_in(fl[1:0]), .preempt_in(preempt),
    .imask_in(imask), .ack_in(ack), .break_req_out(req), .break_lvl_out(lvl),
    .break_pc_out(pc), .addr_err_out(aerr), .irq_out(irq));
  bbc_interrupt_controller_unit_model bbc_interrupt_controller_unit_model_inst (.mclk_in(mclk), .nrst_in(nrst), .req_in(req | aerr),
    .imask_in(imask), .ack_out(ack));

  // ============================================================
  // Access tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk("rdata", {16'h0, e}, {16'h0, rdata});
  endtask : rd_chk
  task automatic cyc_run(input logic [31:0] a, input logic [7:0] f);
    @(posedge mclk);
    cyc <= 1'b1;
    bus_addr <= a;
    fl <= f;
    @(posedge mclk);
    cyc <= 1'b0;
    #1;
  endtask : cyc_run
  task automatic setup(input logic [31:0] ba, input logic [15:0] sel);
    wr_reg(ADDR_BREAK_HIGH, ba[31:16]);
    wr_reg(ADDR_BREAK_LOW, ba[15:0]);
    wr_reg(ADDR_CYCLE_SELECT, sel);
  endtask : setup
  task automatic try(input logic [15:0] sel, input logic [31:0] ba, input logic [31:0] a,
                     input logic [7:0] f, input logic e);
    setup(ba, sel);
    cyc_run(a, f);
    chk("break_req", {31'h0, e}, {31'h0, req});
    if (e) chk("break_pc", a, pc);
  endtask : try
  task automatic wait_req(input logic e);
    for (int i = 0; i < 20 && req !== e; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("break_req", {31'h0, e}, {31'h0, req});
  endtask : wait_req
  // Let the controller accept, then clear all status bits
  task automatic clr();
    @(posedge mclk);
    imask <= 4'h0;
    wait_req(1'b0);
    @(posedge mclk);
    imask <= 4'hf;
    wr_reg(ADDR_STATUS, 16'h0007);
    @(posedge mclk);
    #1;
  endtask : clr
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // ============================================================
  // Test sequence
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_chk(ADDR_CYCLE_SELECT, 16'h0000);
    rd_chk(ADDR_BREAK_HIGH, 16'h0000);
    wr_reg(ADDR_CYCLE_SELECT, 16'hffff);
    rd_chk(ADDR_CYCLE_SELECT, 16'h00ff);
    wr_reg(4'h6, 16'h1234);
    rd_chk(4'h6, 16'h0000);
    chk("level", 32'hf, {28'h0, lvl});
    try(16'h0054, 32'h00000404, 32'h00000404, FT, 1'b1);
    repeat (5) @(posedge mclk);
    chk("held", 32'h1, {31'h0, req});
    rd_chk(ADDR_STATUS, 16'h0001);
    wr_reg(ADDR_MASK, 16'h0001);
    @(posedge mclk);
    #1 chk("irq", 32'h1, {31'h0, irq});
    clr();
    chk("irq", 32'h0, {31'h0, irq});
    wr_reg(ADDR_MASK, 16'h0000);
    try(16'h0058, 32'h0015389c, 32'h0015389c, FT, 1'b0);
    try(16'h0054, 32'h00030147, 32'h00030146, FT, 1'b0);
    try(16'h006a, 32'h00123456, 32'h00123456, WW, 1'b1);
    rd_chk(ADDR_STATUS, 16'h0002);
    @(posedge mclk);
    preempt <= 1'b1;
    @(posedge mclk);
    preempt <= 1'b0;
    #1 chk("break_req", 32'h0, {31'h0, req});
    wr_reg(ADDR_STATUS, 16'h0007);
    try(16'h0066, 32'h00a80391, 32'h00a80391, RW, 1'b0);
    try(16'h00a7, 32'h0076bcdc, 32'h0076bcdc, PL, 1'b1);
    clr();
    try(16'h0094, 32'h002345c8, 32'h002345c8, PF, 1'b0);
    try(16'h0054, 32'h00000404, 32'h00000404, OV, 1'b0);
    try(16'h0074, 32'h00000404, 32'h00000404, OV, 1'b1);
    clr();
    // Destination fetches are never break targets from software
    try(16'h0054, 32'h00000404, 32'h00000404, DS, 1'b0);
    foreach (sels[i]) try(sels[i], 32'h00000404, 32'h00000404, FT, 1'b0);
    setup(32'h00000402, 16'h0054);
    cyc_run(32'h00000400, FT);
    cyc_run(32'h00000402, OV);
    cyc_run(32'h00000404, OV);
    cyc_run(32'h00000500, DS);
    chk("break_req", 32'h0, {31'h0, req});
    cyc_run(32'h00000400, FT);
    cyc_run(32'h00000402, FT);
    chk("break_req", 32'h1, {31'h0, req});
    clr();
    setup(32'h00000404, 16'h0054);
    cyc_run(32'h00000402, FT);
    wr_reg(ADDR_CYCLE_SELECT, 16'h0000);
    cyc_run(32'h00000404, PR);
    chk("break_req", 32'h1, {31'h0, req});
    clr();
    try(16'h0054, 32'h00030147, 32'h00030147, FT, 1'b0);
    chk("addr_err", 32'h1, {31'h0, aerr});
    rd_chk(ADDR_MON, 16'h0005);
    @(posedge mclk);
    imask <= 4'h0;
    wait_req(1'b1);
    wait_req(1'b0);
    report_and_stop();
  end
endmodule : tb_bbc_top
`default_nettype wire
